// [design/plcomc_pkg.sv]
// Package for the operating-mode sequencer: states, register map, timing counts
package plcomc_pkg;
   // Operating modes and internal phases
   typedef enum logic [3:0] {
      ST_STOP,
      ST_SU_CLR_IN,
      ST_SU_ROUTINE,
      ST_RUN_CLR_OUT,
      ST_RUN_READ_IN,
      ST_RUN_MAIN,
      ST_RUN_WRITE_OUT,
      ST_HOLD
   } plcomc_state_type;

   // Reported mode codes
   localparam logic [1:0] MODE_STOP = 2'h0;
   localparam logic [1:0] MODE_STARTUP = 2'h1;
   localparam logic [1:0] MODE_RUN = 2'h2;
   localparam logic [1:0] MODE_HOLD = 2'h3;

   // Register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CYCLE_LIMIT = 8'h08;
   localparam logic [7:0] REG_BREAK = 8'h0C;

   // Control register fields
   localparam int CTRL_RUN_REQ = 0;
   localparam int CTRL_COLD_EXISTS = 1;
   localparam int CTRL_RESUME = 2;
   localparam int CTRL_STEP = 3;
   localparam int CTRL_CLR_WDOG = 4;
   localparam int CTRL_SUBST = 5;

   // Status register fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_WDOG_ERR = 2;
   localparam int STAT_CYC_ERR = 3;
   localparam int STAT_STEP_REFUSED = 4;
   localparam int STAT_OUT_DIS = 5;

   // Breakpoints
   localparam int NUM_BP = 3;
   localparam int BP_STEP_MAX = 2;

   // Timing
   localparam int CLK_MHZ = 200;
   localparam int BLINK_MIN_MS = 3000;
   localparam int WDOG_MS = 100;
   localparam int CYC_MIN_MS = 1;
   localparam int BLINK_HALF_MS = 250;
   localparam int CYC_PER_MS = CLK_MHZ * 1000;
   localparam int BLINK_MIN_CYC = BLINK_MIN_MS * CYC_PER_MS;
   localparam int WDOG_CYC = WDOG_MS * CYC_PER_MS;
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
   localparam logic [15:0] CYC_LIMIT_RST = 16'h0064;

   // Analog stop levels in microamps / millivolts
   localparam logic [15:0] AO_VOLT_STOP = 16'h0000;
   localparam logic [15:0] AO_CUR0_STOP = 16'h0000;
   localparam logic [15:0] AO_CUR4_STOP = 16'h0FA0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [design/plcomc_top.sv]
// Operating-mode sequencer with AXI4-Lite register access
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module plcomc_top
   import plcomc_pkg::*;
#(
   parameter int BLINK_MIN = BLINK_MIN_CYC,
   parameter int WDOG_LIMIT = WDOG_CYC,
   parameter int BLINK_HALF = BLINK_HALF_CYC,
   parameter int MS_CYC = CYC_PER_MS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic run_switch,
   input wire logic startup_done,
   input wire logic main_done,
   input wire logic [NUM_BP-1:0] bp_hit,
   output logic output_disable,
   output logic run_led,
   output logic stop_led,
   output logic startup_routine,
   output logic cold_start_routine,
   output logic main_cycle_routine,
   output logic input_image_clear,
   output logic input_image_read,
   output logic output_image_clear,
   output logic output_image_write,
   output logic timers_run,
   output logic [1:0] mode,
   output logic [15:0] ao_volt,
   output logic [15:0] ao_cur0,
   output logic [15:0] ao_cur4,
   output logic ao_subst
);

   plcomc_state_type state_r;
   logic [31:0] ctrl_r;
   logic [15:0] cyc_limit_r;
   logic [NUM_BP-1:0] bp_en_r;
   logic wdog_err_r;
   logic cyc_err_r;
   logic step_refused_r;
   logic step_grant_r;
   logic cold_r;
   logic [1:0] run_sync_r;
   logic [1:0] su_sync_r;
   logic [1:0] md_sync_r;
   logic [NUM_BP-1:0] bp_sync1_r;
   logic [NUM_BP-1:0] bp_sync2_r;
   logic [31:0] blink_cnt_r;
   logic [31:0] half_cnt_r;
   logic blink_ph_r;
   logic [31:0] wdog_cnt_r;
   logic [31:0] ms_cnt_r;
   logic [15:0] cyc_ms_r;
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bp_count;
   logic wr_fire;
   logic bp_any;
   logic run_req;
   logic wdog_trip;
   logic cyc_trip;
   logic blinking;

   // Synchronise pins from the program engine and the mode switch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_sync_r <= 2'h0;
         su_sync_r <= 2'h0;
         md_sync_r <= 2'h0;
         bp_sync1_r <= '0;
         bp_sync2_r <= '0;
      end else begin
         run_sync_r <= {run_sync_r[0], run_switch};
         su_sync_r <= {su_sync_r[0], startup_done};
         md_sync_r <= {md_sync_r[0], main_done};
         bp_sync1_r <= bp_hit;
         bp_sync2_r <= bp_sync1_r;
      end
   end

   // Count armed breakpoints, one adder stage per entry
   logic [1:0] bp_acc [NUM_BP:0];
   assign bp_acc[0] = 2'h0;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
         assign bp_acc[gi+1] = bp_acc[gi] + {1'b0, bp_en_r[gi]};
      end
   endgenerate
   assign bp_count = bp_acc[NUM_BP];
   assign bp_any = |(bp_sync2_r & bp_en_r);

   // Either switch or software may ask for run
   assign run_req = run_sync_r[1] | ctrl_r[CTRL_RUN_REQ];
   assign wdog_trip = (wdog_cnt_r >= WDOG_LIMIT - 1);
   assign cyc_trip = (cyc_ms_r >= cyc_limit_r) && (cyc_limit_r != 16'h0000);
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

   // Mode sequencer; supervision faults are checked only in ST_RUN_MAIN, where they win over a breakpoint
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_SU_CLR_IN;
         cold_r <= 1'b0;
      end else begin
         case (state_r)
            ST_STOP: begin
               if (run_req && !wdog_err_r) begin
                  state_r <= ST_SU_CLR_IN;
                  cold_r <= 1'b0;
               end else if (run_req && ctrl_r[CTRL_COLD_EXISTS]) begin
                  state_r <= ST_SU_CLR_IN;
                  cold_r <= 1'b1;
               end
            end
            ST_SU_CLR_IN: state_r <= ST_SU_ROUTINE;
            ST_SU_ROUTINE: begin
               if (!run_req) begin
                  state_r <= ST_STOP;
               end else if (su_sync_r[1]) begin
                  state_r <= ST_RUN_CLR_OUT;
               end
            end
            ST_RUN_CLR_OUT: state_r <= ST_RUN_READ_IN;
            ST_RUN_READ_IN: state_r <= ST_RUN_MAIN;
            ST_RUN_MAIN: begin
               if (wdog_trip || cyc_trip || !run_req) begin
                  state_r <= ST_STOP;
               end else if (bp_any) begin
                  state_r <= ST_HOLD;
               end else if (md_sync_r[1] && main_cycle_routine) begin
                  // Strobe gate drops a done left in the synchroniser by the previous pass
                  state_r <= ST_RUN_WRITE_OUT;
               end
            end
            ST_RUN_WRITE_OUT: begin
               state_r <= run_req ? ST_RUN_READ_IN : ST_STOP;
            end
            ST_HOLD: begin
               if (!run_req) begin
                  state_r <= ST_STOP;
               end else if (ctrl_r[CTRL_RESUME] || step_grant_r) begin
                  state_r <= ST_RUN_MAIN;
               end
            end
            default: state_r <= ST_STOP;
         endcase
      end
   end

   // Watchdog counts main-routine time only, frozen in hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdog_cnt_r <= 32'h0;
         ms_cnt_r <= 32'h0;
         cyc_ms_r <= 16'h0;
      end else if (state_r == ST_RUN_MAIN) begin
         wdog_cnt_r <= wdog_cnt_r + 32'h1;
         if (ms_cnt_r >= MS_CYC - 1) begin
            ms_cnt_r <= 32'h0;
            cyc_ms_r <= cyc_ms_r + 16'h1;
         end else begin
            ms_cnt_r <= ms_cnt_r + 32'h1;
         end
      end else if (state_r != ST_HOLD) begin
         wdog_cnt_r <= 32'h0;
         ms_cnt_r <= 32'h0;
         cyc_ms_r <= 16'h0;
      end
   end

   // Sticky fault flags; a trip wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdog_err_r <= 1'b0;
         cyc_err_r <= 1'b0;
      end else begin
         if (state_r == ST_RUN_MAIN && wdog_trip) begin
            wdog_err_r <= 1'b1;
         end else if (state_r == ST_RUN_CLR_OUT && cold_r) begin
            wdog_err_r <= 1'b0;
         end else if (wr_fire && awaddr_r == REG_CTRL && wstrb_r[0]
                      && wdata_r[CTRL_CLR_WDOG]) begin
            wdog_err_r <= 1'b0;
         end
         if (state_r == ST_RUN_MAIN && cyc_trip) begin
            cyc_err_r <= 1'b1;
         end else if (state_r == ST_RUN_CLR_OUT) begin
            cyc_err_r <= 1'b0;
         end
      end
   end

   // Blink window opens with the startup routine and lasts the minimum span
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blink_cnt_r <= 32'h0;
      end else if (state_r == ST_SU_CLR_IN) begin
         blink_cnt_r <= BLINK_MIN;
      end else if (blink_cnt_r != 32'h0) begin
         blink_cnt_r <= blink_cnt_r - 32'h1;
      end
   end
   assign blinking = (blink_cnt_r != 32'h0) || (state_r == ST_SU_ROUTINE);

   // Free-running blink phase
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         half_cnt_r <= 32'h0;
         blink_ph_r <= 1'b0;
      end else if (half_cnt_r >= BLINK_HALF - 1) begin
         half_cnt_r <= 32'h0;
         blink_ph_r <= !blink_ph_r;
      end else begin
         half_cnt_r <= half_cnt_r + 32'h1;
      end
   end

   // Registered outputs toward modules and indicators
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_disable <= 1'b1;
         run_led <= 1'b0;
         stop_led <= 1'b1;
         mode <= MODE_STOP;
         timers_run <= 1'b0;
         ao_volt <= AO_VOLT_STOP;
         ao_cur0 <= AO_CUR0_STOP;
         ao_cur4 <= AO_CUR4_STOP;
         ao_subst <= 1'b0;
      end else begin
         case (state_r)
            ST_STOP: begin
               output_disable <= 1'b1;
               stop_led <= 1'b1;
               run_led <= blinking && blink_ph_r;
               mode <= MODE_STOP;
            end
            ST_SU_CLR_IN, ST_SU_ROUTINE: begin
               output_disable <= 1'b1;
               stop_led <= 1'b1;
               run_led <= blink_ph_r;
               mode <= MODE_STARTUP;
            end
            ST_HOLD: begin
               output_disable <= 1'b1;
               stop_led <= 1'b1;
               run_led <= blink_ph_r;
               mode <= MODE_HOLD;
            end
            default: begin
               output_disable <= 1'b0;
               stop_led <= 1'b0;
               run_led <= blinking ? blink_ph_r : 1'b1;
               mode <= MODE_RUN;
            end
         endcase
         timers_run <= (state_r == ST_RUN_CLR_OUT) || (state_r == ST_RUN_READ_IN)
                       || (state_r == ST_RUN_MAIN) || (state_r == ST_RUN_WRITE_OUT);
         // Same safe levels go to central and decentral stations
         ao_volt <= AO_VOLT_STOP;
         ao_cur0 <= AO_CUR0_STOP;
         ao_cur4 <= AO_CUR4_STOP;
         ao_subst <= ctrl_r[CTRL_SUBST];
      end
   end

   // Phase strobes driving the program engine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         startup_routine <= 1'b0;
         cold_start_routine <= 1'b0;
         main_cycle_routine <= 1'b0;
         input_image_clear <= 1'b0;
         input_image_read <= 1'b0;
         output_image_clear <= 1'b0;
         output_image_write <= 1'b0;
      end else begin
         startup_routine <= (state_r == ST_SU_ROUTINE) && !cold_r;
         cold_start_routine <= (state_r == ST_SU_ROUTINE) && cold_r;
         main_cycle_routine <= (state_r == ST_RUN_MAIN);
         input_image_clear <= (state_r == ST_SU_CLR_IN);
         input_image_read <= (state_r == ST_RUN_READ_IN);
         output_image_clear <= (state_r == ST_RUN_CLR_OUT);
         output_image_write <= (state_r == ST_RUN_WRITE_OUT);
      end
   end

   // Single step request: refused when too many breakpoints are armed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_grant_r <= 1'b0;
         step_refused_r <= 1'b0;
      end else begin
         step_grant_r <= 1'b0;
         if (wr_fire && awaddr_r == REG_CTRL && wstrb_r[0] && wdata_r[CTRL_STEP]
             && state_r == ST_HOLD) begin
            if (bp_count > BP_STEP_MAX[1:0]) begin
               step_refused_r <= 1'b1;
            end else begin
               step_grant_r <= 1'b1;
               step_refused_r <= 1'b0;
            end
         end
      end
   end

   // AXI write channel: address and data accepted independently
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r == REG_CTRL || awaddr_r == REG_CYCLE_LIMIT
                            || awaddr_r == REG_BREAK || awaddr_r == REG_STATUS)
                           ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;

   // Writable registers; resume and step are self-clearing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= 32'h0;
         cyc_limit_r <= CYC_LIMIT_RST;
         bp_en_r <= '0;
      end else begin
         ctrl_r[CTRL_RESUME] <= 1'b0;
         ctrl_r[CTRL_STEP] <= 1'b0;
         ctrl_r[CTRL_CLR_WDOG] <= 1'b0;
         if (wr_fire && awaddr_r == REG_CTRL && wstrb_r[0]) begin
            ctrl_r[5:0] <= wdata_r[5:0];
         end
         if (wr_fire && awaddr_r == REG_CYCLE_LIMIT) begin
            if (wstrb_r[0]) cyc_limit_r[7:0] <= wdata_r[7:0];
            if (wstrb_r[1]) cyc_limit_r[15:8] <= wdata_r[15:8];
         end
         if (wr_fire && awaddr_r == REG_BREAK && wstrb_r[0]) begin
            bp_en_r <= wdata_r[NUM_BP-1:0];
         end
      end
   end

   // AXI read channel, one cycle to answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL: s_axi_rdata <= {26'h0, ctrl_r[5:0]};
            REG_STATUS: s_axi_rdata <= {26'h0, output_disable, step_refused_r,
                                        cyc_err_r, wdog_err_r, mode};
            REG_CYCLE_LIMIT: s_axi_rdata <= {16'h0, cyc_limit_r};
            REG_BREAK: s_axi_rdata <= {29'h0, bp_en_r};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;

endmodule

// [tb/plcomc_chk_sva.sv]
// Port assertions for the operating-mode sequencer
`timescale 1ns/1ps
module plcomc_chk
   import plcomc_pkg::*;
#(
   parameter int BLINK_MIN = 100,
   parameter int WDOG_LIMIT = 50
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic output_disable,
   input wire logic run_led,
   input wire logic stop_led,
   input wire logic startup_routine,
   input wire logic cold_start_routine,
   input wire logic main_cycle_routine,
   input wire logic input_image_clear,
   input wire logic input_image_read,
   input wire logic output_image_clear,
   input wire logic output_image_write,
   input wire logic timers_run,
   input wire logic [1:0] mode,
   input wire logic [15:0] ao_volt,
   input wire logic [15:0] ao_cur0,
   input wire logic [15:0] ao_cur4
);
   int bl_cnt;
   int mn_cnt;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Age of the latest start routine; saturates so steady-on can be judged later
   always_ff @(posedge aclk) begin
      if (!aresetn) bl_cnt <= 0;
      else if ($rose(startup_routine || cold_start_routine)) bl_cnt <= 1;
      else if (bl_cnt != 0 && bl_cnt < BLINK_MIN + 20) bl_cnt <= bl_cnt + 1;
   end
   // Length of the current main routine phase
   always_ff @(posedge aclk) begin
      mn_cnt <= (!aresetn || !main_cycle_routine) ? 0 : mn_cnt + 1;
   end
   property p_stop; mode == MODE_STOP |-> output_disable && stop_led; endproperty
   a_stop: assert property (p_stop) else $error("stop outputs wrong");
   property p_startup; mode == MODE_STARTUP |-> output_disable; endproperty
   a_startup: assert property (p_startup) else $error("startup outputs on");
   property p_run; mode == MODE_RUN |-> !output_disable && !stop_led && timers_run; endproperty
   a_run: assert property (p_run) else $error("run outputs wrong");
   property p_hold;
      mode == MODE_HOLD |-> output_disable && stop_led && !timers_run && !main_cycle_routine;
   endproperty
   a_hold: assert property (p_hold) else $error("hold outputs wrong");
   property p_su; startup_routine |-> mode == MODE_STARTUP && stop_led; endproperty
   a_su: assert property (p_su) else $error("startup routine out of mode");
   property p_clr_first; $rose(startup_routine) |-> $past(input_image_clear); endproperty
   a_clr_first: assert property (p_clr_first) else $error("inputs not cleared first");
   property p_clr_out; output_image_clear |=> input_image_read; endproperty
   a_clr_out: assert property (p_clr_out) else $error("no read after clear");
   property p_order; input_image_read |=> main_cycle_routine; endproperty
   a_order: assert property (p_order) else $error("main not after read");
   property p_write; output_image_write |-> $past(main_cycle_routine); endproperty
   a_write: assert property (p_write) else $error("write not after main");
   property p_main; main_cycle_routine |-> mode == MODE_RUN; endproperty
   a_main: assert property (p_main) else $error("main outside run");
   property p_ao;
      mode == MODE_STOP |-> ao_volt == AO_VOLT_STOP && ao_cur0 == AO_CUR0_STOP
         && ao_cur4 == AO_CUR4_STOP;
   endproperty
   a_ao: assert property (p_ao) else $error("analog stop levels wrong");
   property p_blink;
      bl_cnt > 0 && bl_cnt < BLINK_MIN - 10 |-> ##[1:9] run_led != $past(run_led);
   endproperty
   a_blink: assert property (p_blink) else $error("run lamp not blinking");
   property p_steady; mode == MODE_RUN && bl_cnt == BLINK_MIN + 20 |-> run_led; endproperty
   a_steady: assert property (p_steady) else $error("run lamp not steady");
   property p_wdog; mn_cnt <= WDOG_LIMIT + 4; endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog late");
   c_hold: cover property (mode == MODE_HOLD);
   c_cold: cover property (cold_start_routine);
   c_trip: cover property (mode == MODE_RUN ##1 mode == MODE_STOP);
endmodule

bind plcomc_top plcomc_chk #(.BLINK_MIN(BLINK_MIN), .WDOG_LIMIT(WDOG_LIMIT)) chk_u (
   .aclk(aclk), .aresetn(aresetn), .output_disable(output_disable), .run_led(run_led),
   .stop_led(stop_led), .startup_routine(startup_routine),
   .cold_start_routine(cold_start_routine), .main_cycle_routine(main_cycle_routine),
   .input_image_clear(input_image_clear), .input_image_read(input_image_read),
   .output_image_clear(output_image_clear), .output_image_write(output_image_write),
   .timers_run(timers_run), .mode(mode), .ao_volt(ao_volt), .ao_cur0(ao_cur0),
   .ao_cur4(ao_cur4));

// [tb/plcomc_io_model.sv]
// Model of the program side that finishes routines after a set delay
`timescale 1ns/1ps
module plcomc_io_model (
   input wire logic aclk,
   input wire logic startup_routine,
   input wire logic cold_start_routine,
   input wire logic main_cycle_routine,
   input wire logic [7:0] delay,
   output logic startup_done,
   output logic main_done
);
   logic [7:0] su_cnt = 8'h00;
   logic [7:0] mn_cnt = 8'h00;
   // Run time of each routine; a long delay shows start-up is not timed
   always_ff @(posedge aclk) begin
      su_cnt <= (startup_routine || cold_start_routine) ? su_cnt + 8'h01 : 8'h00;
      mn_cnt <= main_cycle_routine ? mn_cnt + 8'h01 : 8'h00;
   end
   // Done is a level that falls as soon as the phase ends
   assign startup_done = (startup_routine || cold_start_routine) && su_cnt >= delay;
   assign main_done = main_cycle_routine && mn_cnt >= delay;
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the operating-mode sequencer
`timescale 1ns/1ps
module tb_top
   import plcomc_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, run_switch = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, io_delay = 8'h03;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [2:0] bp_hit = 3'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, mode, resp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic startup_done, main_done, output_disable, run_led, stop_led, startup_routine;
   logic cold_start_routine, main_cycle_routine, input_image_clear, input_image_read;
   logic output_image_clear, output_image_write, timers_run, ao_subst;
   logic [15:0] ao_volt, ao_cur0, ao_cur4;
   int n_errors = 0, n_compared = 0;
   // 200 MHz clock
   initial forever #2.5 aclk = ~aclk;
   plcomc_top #(.BLINK_MIN(100), .WDOG_LIMIT(50), .BLINK_HALF(4), .MS_CYC(10)) dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .run_switch, .startup_done, .main_done, .bp_hit,
      .output_disable, .run_led, .stop_led, .startup_routine, .cold_start_routine,
      .main_cycle_routine, .input_image_clear, .input_image_read, .output_image_clear,
      .output_image_write, .timers_run, .mode, .ao_volt, .ao_cur0, .ao_cur4, .ao_subst);
   plcomc_io_model io_u (.aclk, .startup_routine, .cold_start_routine, .main_cycle_routine,
      .delay(io_delay), .startup_done, .main_done);
   task complete_run;
      $display("errors %0d compares %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task bad(input string what);
      n_errors++;
      $display("BAD %0t %s", $time, what);
      complete_run();
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // Handshakes are judged at the falling edge, where every party is settled
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int i;
      logic aw_t, w_t, b_t;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i <= 100; i++) begin
         @(negedge aclk);
         aw_t = s_axi_awvalid && s_axi_awready;
         w_t = s_axi_wvalid && s_axi_wready;
         b_t = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
         if (b_t) s_axi_bready <= 1'b0;
         if (b_t) break;
      end
      if (i > 100) bad("write timeout");
   endtask
   task axi_rd(input logic [7:0] a);
      int i;
      logic ar_t, r_t;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i <= 100; i++) begin
         @(negedge aclk);
         ar_t = s_axi_arvalid && s_axi_arready;
         r_t = s_axi_rvalid;
         rd = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (ar_t) s_axi_arvalid <= 1'b0;
         if (r_t) s_axi_rready <= 1'b0;
         if (r_t) break;
      end
      if (i > 100) bad("read timeout");
   endtask
   task wait_mode(input logic [1:0] m, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(negedge aclk);
         if (mode === m) break;
      end
      if (mode !== m) bad("mode wait timeout");
   endtask
   // Main sequence: reset, registers, run, hold, stop, faults
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (110) @(negedge aclk); // Past the power-on blink window
      chk(mode, MODE_STOP, "reset mode");
      chk(run_led, 1'b0, "stop run lamp");
      axi_rd(REG_CTRL);
      chk(rd, 32'h0, "ctrl reset");
      axi_rd(REG_CYCLE_LIMIT);
      chk(rd, {16'h0000, CYC_LIMIT_RST}, "limit reset");
      axi_rd(REG_BREAK);
      chk(rd, 32'h0, "break reset");
      axi_wr(REG_STATUS, 32'hFFFFFFFF, 4'hF);
      chk({30'h0, resp}, {30'h0, RESP_OKAY}, "status write resp");
      axi_rd(REG_STATUS);
      chk(rd, 32'h1 << STAT_OUT_DIS, "status read only");
      axi_rd(8'h10);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped resp");
      chk(rd, 32'h0, "unmapped data");
      axi_wr(REG_CYCLE_LIMIT, 32'h0000AB05, 4'h1);
      axi_rd(REG_CYCLE_LIMIT);
      chk(rd, 32'h00000005, "limit byte lane");
      axi_wr(REG_CYCLE_LIMIT, 32'h0, 4'hF);
      @(posedge aclk);
      run_switch <= 1'b1;
      wait_mode(MODE_RUN, 100);
      repeat (40) @(negedge aclk);
      chk(mode, MODE_RUN, "stays running");
      chk(output_disable, 1'b0, "run outputs on");
      axi_wr(REG_BREAK, 32'h1, 4'hF);
      @(posedge aclk);
      bp_hit <= 3'h1;
      wait_mode(MODE_HOLD, 100);
      chk(timers_run, 1'b0, "hold timers");
      axi_wr(REG_BREAK, 32'h3, 4'hF);
      axi_wr(REG_CTRL, 32'h1 << CTRL_STEP, 4'hF);
      wait_mode(MODE_HOLD, 100);
      axi_rd(REG_STATUS);
      chk(rd[STAT_STEP_REFUSED], 1'b0, "two points step");
      axi_wr(REG_BREAK, 32'h7, 4'hF);
      axi_wr(REG_CTRL, 32'h1 << CTRL_STEP, 4'hF);
      axi_rd(REG_STATUS);
      chk(rd[STAT_STEP_REFUSED], 1'b1, "three points step");
      chk(rd[1:0], MODE_HOLD, "still hold");
      @(posedge aclk);
      bp_hit <= 3'h0;
      axi_wr(REG_BREAK, 32'h0, 4'hF);
      axi_wr(REG_CTRL, 32'h1 << CTRL_RESUME, 4'hF);
      wait_mode(MODE_RUN, 100);
      @(posedge aclk);
      run_switch <= 1'b0;
      wait_mode(MODE_STOP, 100);
      axi_wr(REG_CTRL, 32'h1 << CTRL_SUBST, 4'hF);
      @(negedge aclk);
      chk(ao_subst, 1'b1, "substitute select");
      io_delay <= 8'd80;
      axi_wr(REG_CTRL, 32'h1, 4'hF);
      wait_mode(MODE_RUN, 300);
      wait_mode(MODE_STOP, 200);
      axi_rd(REG_STATUS);
      chk(rd[STAT_WDOG_ERR], 1'b1, "watchdog flag");
      repeat (60) @(negedge aclk);
      chk(mode, MODE_STOP, "no restart without cold start");
      io_delay <= 8'd3;
      axi_wr(REG_CTRL, 32'h3, 4'hF);
      wait_mode(MODE_RUN, 200);
      axi_rd(REG_STATUS);
      chk(rd[STAT_WDOG_ERR], 1'b0, "flag cleared by cold start");
      io_delay <= 8'd30;
      axi_wr(REG_CYCLE_LIMIT, 32'h1, 4'h3);
      wait_mode(MODE_STOP, 300);
      axi_rd(REG_STATUS);
      chk(rd[STAT_CYC_ERR], 1'b1, "cycle limit flag");
      complete_run();
   end
endmodule
